/* tcsl_defs.vh */
// How it works
// [RQ1] terminate is asserted only after arm was established earlier in the sequence.
// [RQ2] arm asserts when tones a and c are both present; the code arms from idle only while tone b is absent.
// [RQ3] after arm, losing tone c keeps arm while tone a persists.
// [RQ4] armed with a and c, removing c and applying b asserts terminate.
// [RQ5] the ground source may overlap tones a, b and c briefly.
// [RQ6] b and c overlap drops or blocks neither arm nor terminate.
// [RQ7] terminate stays on continuously while tones a and b are present.
// [RQ8] a and c, then c off with arm held, then b on gives terminate.
// [RQ9] check-channel tone presence drives a dedicated telemetry output.
// [RQ10] check-channel tone has no effect on any command output.
// [RQ11] check channel comes from tone d when tone d is configured.
// [RQ12] command outputs assert 4 ms to 25 ms after a valid tone appears.
// [RQ13] after first reception, outputs appear within the same response time.
// [RQ14] no command output when a tone of the sequence is dropped or missing.
// [RQ15] any other tone combination produces no command output; the code drives optional_cmd when b and c are present without a.
// [RQ16] physical channel to logical tone mapping is a parameter.
// [RQ17] inputs are synchronised; reset clears arm and terminate.
`ifndef TCSL_DEFS_VH
`define TCSL_DEFS_VH
`define TCSL_CLK_MHZ 250
`define TCSL_RESP_MIN_US 4000
`define TCSL_RESP_MAX_US 25000
// qualification time: a bit above the least time, well under the longest
`define TCSL_QUAL_US 5000
`define TCSL_QUAL_CYCLES (`TCSL_QUAL_US * `TCSL_CLK_MHZ)
`define TCSL_ST_IDLE 2'h0
`define TCSL_ST_ARM 2'h1
`define TCSL_ST_TERM 2'h2
`define TCSL_NUM_CH 8
`define TCSL_CH_A 1
`define TCSL_CH_B 2
`define TCSL_CH_C 5
`define TCSL_CH_D 4
`define TCSL_D_EN 1'h1
`endif

/* tcsl_sync.v */
`timescale 1ns/1ns
// two-stage synchroniser per tone channel
module tcsl_sync #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   // first stage feeds only the second stage
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         meta <= d; // RQ17
         q <= meta;
      end
   end
endmodule // tcsl_sync

/* tcsl_qual.v */
`timescale 1ns/1ns
// presence qualifier: a tone counts only once steady for QUAL cycles
module tcsl_qual #(
   parameter WIDTH = 4,
   parameter QUAL = 1250000
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] raw,
   output reg [WIDTH-1:0] valid
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_ch
         reg [21:0] cnt;
         // drop is immediate so a vanished tone never holds a command; rise waits
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt <= 22'h0;
               valid[i] <= 1'b0;
            end else if (!raw[i]) begin
               cnt <= 22'h0;
               valid[i] <= 1'b0; // RQ14
            end else if (cnt >= QUAL[21:0] - 22'h1) begin
               valid[i] <= 1'b1; // RQ12
            end else begin
               cnt <= cnt + 22'h1;
            end
         end
      end
   endgenerate
endmodule // tcsl_qual

/* tcsl_top.v */
`timescale 1ns/1ns
`include "tcsl_defs.vh"
// command sequence logic of the tone termination_receiver
module tcsl_top #(
   parameter NUM_CH = `TCSL_NUM_CH,
   parameter CH_A = `TCSL_CH_A,
   parameter CH_B = `TCSL_CH_B,
   parameter CH_C = `TCSL_CH_C,
   parameter CH_D = `TCSL_CH_D,
   parameter D_EN = `TCSL_D_EN,
   parameter QUAL = `TCSL_QUAL_CYCLES
) (
   input wire clk,
   input wire arst_n,
   input wire [NUM_CH-1:0] tone_present,
   output reg arm,
   output reg terminate,
   output reg monitor,
   output reg check_channel,
   output reg optional_cmd
);
   wire [NUM_CH-1:0] tone_sync;
   wire [3:0] tone_raw;
   wire [3:0] tone_ok;
   wire ta;
   wire tb;
   wire tc;
   wire td;
   reg [1:0] state;
   reg [1:0] next_state;

   tcsl_sync #(.WIDTH(NUM_CH)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(tone_present),
      .q(tone_sync)
   );

   // logical tone selection from configured physical channels
   assign tone_raw = {(D_EN != 0) & tone_sync[CH_D], tone_sync[CH_C], tone_sync[CH_B], tone_sync[CH_A]}; // RQ16 RQ11

   tcsl_qual #(.WIDTH(4), .QUAL(QUAL)) u_qual (
      .clk(clk),
      .arst_n(arst_n),
      .raw(tone_raw),
      .valid(tone_ok)
   );

   assign ta = tone_ok[0];
   assign tb = tone_ok[1];
   assign tc = tone_ok[2];
   assign td = tone_ok[3];

   // sequence: tone d never enters this decode, so check channel is isolated
   always @* begin
      next_state = state;
      case (state)
         `TCSL_ST_IDLE: begin
            // b present first is not an arm; a and c alone arm
            if (ta && tc && !tb) next_state = `TCSL_ST_ARM; // RQ2 RQ15
         end
         `TCSL_ST_ARM: begin
            if (!ta) next_state = `TCSL_ST_IDLE; // RQ14
            else if (tb && !tc) next_state = `TCSL_ST_TERM; // RQ4 RQ8 RQ1
            else next_state = `TCSL_ST_ARM; // RQ3 RQ5 RQ6
         end
         `TCSL_ST_TERM: begin
            if (ta && tb) next_state = `TCSL_ST_TERM; // RQ7
            // b gone while a stays: fall back to armed so arm never blinks
            else if (ta) next_state = `TCSL_ST_ARM; // RQ3
            else next_state = `TCSL_ST_IDLE; // RQ14
         end
         default: next_state = `TCSL_ST_IDLE;
      endcase
   end

   // outputs registered; qualification delay plus three cycles sets response time
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= `TCSL_ST_IDLE; // RQ17
         arm <= 1'b0;
         terminate <= 1'b0;
         monitor <= 1'b0;
         check_channel <= 1'b0;
         optional_cmd <= 1'b0;
      end else begin
         state <= next_state;
         arm <= (next_state == `TCSL_ST_ARM) || (next_state == `TCSL_ST_TERM); // RQ6 RQ13
         terminate <= (next_state == `TCSL_ST_TERM); // RQ1 RQ12
         monitor <= tc;
         check_channel <= td; // RQ9 RQ10
         optional_cmd <= tb && tc && !ta; // RQ15
      end
   end
endmodule // tcsl_top

/* tcsl_tone_src.sv */
`timescale 1ns/1ns
// ground tone source: puts the asked tone set on the decoder lines after an edge
module tcsl_tone_src (
   input wire clk,
   input wire [7:0] want,
   output reg [7:0] tone_present
);
   // tones may overlap in any order, so b can come before c goes
   initial tone_present = 8'h00;
   always @(posedge clk) tone_present <= want;
endmodule // tcsl_tone_src

/* tcsl_chk_sva.sv */
`timescale 1ns/1ns
`include "tcsl_defs.vh"
module tcsl_chk #(parameter QUAL = 10) (
   input wire clk,
   input wire arst_n,
   input wire [7:0] tone_present,
   input wire arm,
   input wire terminate,
   input wire monitor,
   input wire check_channel
);
   wire ta = tone_present[`TCSL_CH_A];
   wire tb = tone_present[`TCSL_CH_B];
   wire tc = tone_present[`TCSL_CH_C];
   wire td = tone_present[`TCSL_CH_D];
   reg [31:0] ac_cnt;
   reg [31:0] c_cnt;
   // cycles of tone c steady at its pin, for the late bound of the response
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) c_cnt <= 32'h0;
      else c_cnt <= tc ? c_cnt + 32'h1 : 32'h0;
   end
   // cycles of a and c steady at the pins, before the synchroniser
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) ac_cnt <= 32'h0;
      else ac_cnt <= (ta && tc) ? ac_cnt + 32'h1 : 32'h0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_a; ta [*5]; endsequence
   sequence s_ab; (ta && tb) [*5]; endsequence
   a_term_arm: assert property (terminate |-> arm) else $error("terminate without arm");
   a_term_after: assert property ($rose(terminate) |-> $past(arm)) else $error("terminate first");
   a_arm_min: assert property ($rose(arm) |-> ac_cnt >= QUAL) else $error("arm too early");
   a_arm_keep: assert property (s_a ##0 arm |=> arm) else $error("arm dropped");
   a_term_keep: assert property (s_ab ##0 terminate |=> terminate) else $error("terminate lost");
   a_a_lost: assert property ($fell(ta) |-> ##[1:5] !arm) else $error("arm without a");
   a_mon_drop: assert property ($fell(tc) |-> ##[1:5] !monitor) else $error("monitor stuck");
   a_mon_late: assert property (c_cnt >= QUAL + 3 |-> monitor) else $error("monitor late");
   a_chk_drop: assert property ($fell(td) |-> ##[1:5] !check_channel) else $error("check stuck");
   a_reset_clr: assert property (disable iff (1'b0) !arst_n |-> !arm && !terminate) else $error("reset");
endmodule // tcsl_chk
bind tcsl_top tcsl_chk #(.QUAL(QUAL)) i_chk (.clk, .arst_n, .tone_present, .arm, .terminate, .monitor, .check_channel);

/* testbench.sv */
`timescale 1ns/1ns
`include "tcsl_defs.vh"
module testbench;
   localparam Q = 10;
   // nibbles {0,a,b,c}, first step in the top nibble
   localparam [55:0] SEQ = 56'h06375765462540;
   reg clk = 1'b0;
   reg arst_n = 1'b1;
   reg [7:0] want = 8'h00;
   reg [31:0] rng = 32'h18;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer st = 0;
   reg [2:0] prev = 3'h0;
   integer i;
   wire [7:0] tp;
   wire arm, terminate, monitor, check_channel, optional_cmd;
   tcsl_tone_src i_tcsl_tone_src (.clk(clk), .want(want), .tone_present(tp));
   tcsl_top #(.QUAL(Q)) i_tcsl_top (.clk(clk), .arst_n(arst_n), .tone_present(tp), .arm(arm),
      .terminate(terminate), .monitor(monitor), .check_channel(check_channel), .optional_cmd(optional_cmd));
   initial forever #2 clk = ~clk;
   function [31:0] xs(input [31:0] v);
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   task check(input [4:0] seen, input [4:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t outputs %b expected %b", $time, seen, exp);
      end
   endtask
   // model: one update of the sequence state for a qualified tone set {a,b,c}
   function integer nxt(input integer s, input [2:0] t);
      begin
         if (!t[2]) nxt = 0;
         else if (s == 0) nxt = (t[0] && !t[1]) ? 1 : 0;
         else if (s == 1) nxt = (t[1] && !t[0]) ? 2 : 1;
         else nxt = t[1] ? 2 : 1;
      end
   endfunction
   // apply a tone set, random d and spare channels, then compare once settled
   task step(input [3:0] t);
      reg [7:0] w;
      begin
         rng = xs(rng);
         w = rng[7:0] & 8'hd9;
         w[`TCSL_CH_A] = t[2];
         w[`TCSL_CH_B] = t[1];
         w[`TCSL_CH_C] = t[0];
         @(posedge clk) want <= w;
         repeat (Q + 12) @(posedge clk);
         // dropped tones reach the logic a qualification time before new ones
         st = nxt(nxt(st, prev & t[2:0]), t[2:0]);
         prev = t[2:0];
         #1 check({arm, terminate, monitor, check_channel, optional_cmd},
            {st != 0, st == 2, t[0], w[`TCSL_CH_D], t[1] && t[0] && !t[2]});
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d miscompares %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // watchdog: the sequence needs some 1.6 us
   initial begin
      #20000;
      miscompares = miscompares + 1;
      end_of_test;
   end
   // reset falls off the clock edge so the flops are clear before the first edge
   initial begin
      #1 arst_n = 1'b0;
      repeat (4) @(posedge clk);
      check({arm, terminate, monitor, check_channel, optional_cmd}, 5'h00);
      arst_n <= 1'b1;
      for (i = 13; i >= 0; i = i - 1) step(SEQ[4*i +: 4]);
      // arm, terminate, then reset in mid-run: both must clear and stay clear
      step(4'h5);
      step(4'h6);
      @(posedge clk) arst_n <= 1'b0;
      #1 check({arm, terminate, monitor, check_channel, optional_cmd}, 5'h00);
      st = 0;
      prev = 3'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      step(4'h6);
      end_of_test;
   end
endmodule // testbench
